// ==== core/nic_pkg.sv ====
// shared constants and carrier types of the nested interrupt priority block
package nic_pkg;
    // register offsets, one byte register each
    localparam logic [7:0] OFF_SW_PRIO_0  = 8'h24;
    localparam logic [7:0] OFF_SW_PRIO_3  = 8'h27;
    localparam logic [7:0] OFF_EXT_SENSE  = 8'h28;
    localparam logic [7:0] RST_SW_PRIO    = 8'hff;
    localparam logic [7:0] RST_EXT_SENSE  = 8'h00;
    localparam logic [7:0] EXT_SENSE_MASK = 8'hfc;
    localparam logic [3:0] PRIO3_FIXED_HI = 4'hf;
    // ext_irq_sense_ctrl field positions
    localparam int SENSE_UPPER_POS = 6;
    localparam int POL_PORT_B_POS  = 5;
    localparam int SENSE_LOWER_POS = 3;
    localparam int POL_PORT_A_POS  = 2;
    // current level codes (hi, lo)
    localparam logic [1:0] LVL_0 = 2'b10;
    localparam logic [1:0] LVL_1 = 2'b01;
    localparam logic [1:0] LVL_2 = 2'b00;
    localparam logic [1:0] LVL_3 = 2'b11;
    // condition register layout
    localparam int CC_HI_POS = 5;
    localparam int CC_LO_POS = 3;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    // vector table
    localparam int         NUM_VEC        = 14;
    localparam logic [15:0] VEC_RESET     = 16'hfffe;
    localparam logic [15:0] VEC_TRAP      = 16'hfffc;
    localparam logic [15:0] VEC_PAIR0     = 16'hfffa;
    localparam logic [3:0] SRC_TIME_BASE  = 4'h1;
    localparam logic [3:0] SRC_EXT0       = 4'h2;
    localparam logic [13:0] HALT_WAKE_MASK = 14'h00be;

    // one-cycle pulses from the cpu core; at most one of them per cycle
    typedef struct packed {
        logic       irq_enter;
        logic       trap_enter;
        logic       irq_return;
        logic       pop_cc;
        logic       enable_irq;
        logic       disable_irq;
        logic       halt;
        logic       wait_irq;
        logic [3:0] vec_sel;
        logic [7:0] pop_data;
    } nic_cpu_evt_t;

    // low power state of the core, levels
    typedef struct packed {
        logic in_halt;
        logic in_active_halt;
    } nic_power_t;
endpackage

// ==== core/nic_top.sv ====
// software priority store, current level tracking and external line sensing
// How it works
// - two-bit priority per maskable vector, same code as current level bits
// - a pair written with level-0 code keeps its old value
// - priority registers reset to ones; fourth register bits 7:4 read ones
// - reset and trap have no stored priority; servicing them sets level 3
// - raising the running vector's priority while still pending re-enters it
// - enable, halt and wait load 10; disable and trap load 11
// - masked jump when level is 11, unmasked jump otherwise
// - level set by these instructions stays until next return or such instruction
// - pair 0 serves vector FFFAh, each lower vector the next pair, up to 13
// - reset FFFEh, trap FFFCh; listed sources wake from halt, others do not
// - with FLASH_PART set, active halt is left only on reset or time-base interrupt, else as halt
// - lines trigger on fall, rise, both, fall plus low; rise plus high lines 0, 2
// - sensitivity and polarity bits change only at level 3
// - changing any sensitivity or polarity value clears pending external requests
// - sense control resets to zero with fields at 7:6, 5, 4:3, 2 and zero 1:0
// - upper field codes for line 2: fall+low, rise, fall, both; line 3 same
// - port B polarity inverts line 2 codes; both edges unchanged
// - lower field drives lines 0 and 1 like the upper field drives 2 and 3
// - port A polarity inverts line 0 selection when set
// - edge requests latch and clear when their routine is entered
`timescale 1ns/1ps
module nic_top #(
    parameter bit FLASH_PART = 1'b1
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // cpu core side
    input  wire nic_pkg::nic_cpu_evt_t cpu_evt,
    input  wire nic_pkg::nic_power_t   power,
    output logic      [7:0]            cond_code_reg,
    output logic                       jump_if_masked,
    output logic                       jump_if_unmasked,
    output logic      [15:0]           service_vector,
    output logic                       reentry_req,
    output logic                       wake_req,
    // interrupt sources
    input  wire logic [3:0]            ext_line,
    input  wire logic [13:0]           periph_pend,
    output logic      [13:0]           irq_pending
);
    import nic_pkg::*;

    // rank 0..3 of a level code, so that levels compare numerically
    function automatic logic [1:0] level_rank(input logic [1:0] code);
        unique case (code)
            LVL_0:   level_rank = 2'd0;
            LVL_1:   level_rank = 2'd1;
            LVL_2:   level_rank = 2'd2;
            default: level_rank = 2'd3;
        endcase
    endfunction

    // trigger set {fall, rise, low level, high level} of a sense code
    function automatic logic [3:0] sense_mode(input logic [1:0] code, input logic inv);
        unique case (code)
            2'b00:   sense_mode = inv ? 4'b0101 : 4'b1010;
            2'b01:   sense_mode = inv ? 4'b1000 : 4'b0100;
            2'b10:   sense_mode = inv ? 4'b0100 : 4'b1000;
            default: sense_mode = 4'b1100;
        endcase
    endfunction

    logic [1:0]  prio_reg [NUM_VEC];
    logic [7:0]  sense_reg;
    logic [1:0]  cur_level_reg;
    logic [1:0]  cur_level_next;
    logic [3:0]  flags_reg;
    logic [3:0]  active_vec_reg;
    logic        active_valid_reg;
    logic [3:0]  ext_prev_reg;
    logic        edge_armed_reg;
    logic [3:0]  ext_pend_reg;
    logic [3:0]  edge_set;
    logic [3:0]  edge_clr;
    logic [3:0]  level_req;
    logic [13:0] req;
    logic        sense_wr_ok;
    logic        sense_change;
    logic        reentry_hit;

    // per-line trigger decode: lines 0/1 from the lower field, 2/3 from the upper
    logic [3:0] mode [4];
    always_comb
    begin
        mode[0] = sense_mode(sense_reg[SENSE_LOWER_POS +: 2],
                             sense_reg[POL_PORT_A_POS]);
        mode[1] = sense_mode(sense_reg[SENSE_LOWER_POS +: 2], 1'b0);
        mode[2] = sense_mode(sense_reg[SENSE_UPPER_POS +: 2],
                             sense_reg[POL_PORT_B_POS]);
        mode[3] = sense_mode(sense_reg[SENSE_UPPER_POS +: 2], 1'b0);
    end

    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            // edges are ignored in the first cycle after reset, the previous
            // sample is not yet real and would fake an edge
            edge_set[k] = edge_armed_reg &&
                          ((mode[k][3] && ext_prev_reg[k] && !ext_line[k]) ||
                           (mode[k][2] && !ext_prev_reg[k] && ext_line[k]));
            level_req[k] = (mode[k][1] && !ext_line[k]) ||
                           (mode[k][0] && ext_line[k]);
            edge_clr[k] = cpu_evt.irq_enter &&
                          cpu_evt.vec_sel == SRC_EXT0 + 4'(k);
        end
    end

    assign sense_wr_ok  = reg_wr && reg_addr == OFF_EXT_SENSE &&
                          cur_level_reg == LVL_3;
    assign sense_change = sense_wr_ok &&
                          ((reg_wdata & EXT_SENSE_MASK) != sense_reg);

    always_comb
    begin
        req = periph_pend;
        for (int k = 0; k < 4; k++)
        begin
            req[SRC_EXT0 + 4'(k)] = ext_pend_reg[k] | level_req[k] | periph_pend[SRC_EXT0 + 4'(k)];
        end
    end

    // priority store, one two-bit pair per vector
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NUM_VEC; i++)
            begin
                prio_reg[i] <= RST_SW_PRIO[1:0];
            end
        end
        else if (reg_wr)
        begin
            for (int i = 0; i < NUM_VEC; i++)
            begin
                if (reg_addr == OFF_SW_PRIO_0 + 8'(i / 4) &&
                    reg_wdata[2 * (i % 4) +: 2] != LVL_0)
                begin
                    prio_reg[i] <= reg_wdata[2 * (i % 4) +: 2];
                end
            end
        end
    end

    // sensitivity control; reserved low bits are kept at zero whatever is written
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sense_reg <= RST_EXT_SENSE;
        end
        else if (sense_wr_ok)
        begin
            sense_reg <= reg_wdata & EXT_SENSE_MASK;
        end
    end

    // external edge latches; a new edge wins over any clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_prev_reg   <= 4'h0;
            edge_armed_reg <= 1'b0;
            ext_pend_reg   <= 4'h0;
        end
        else
        begin
            ext_prev_reg   <= ext_line;
            edge_armed_reg <= 1'b1;
            ext_pend_reg   <= (ext_pend_reg & ~edge_clr & ~{4{sense_change}})
                              | edge_set;
        end
    end

    // current level: hardware entry, instructions and pops
    always_comb
    begin
        cur_level_next = cur_level_reg;
        if (cpu_evt.trap_enter)
            cur_level_next = LVL_3;
        else if (cpu_evt.irq_enter && cpu_evt.vec_sel < 4'(NUM_VEC))
            cur_level_next = prio_reg[cpu_evt.vec_sel];
        else if (cpu_evt.irq_return || cpu_evt.pop_cc)
            cur_level_next = {cpu_evt.pop_data[CC_HI_POS],
                              cpu_evt.pop_data[CC_LO_POS]};
        else if (cpu_evt.disable_irq)
            cur_level_next = LVL_3;
        else if (cpu_evt.enable_irq || cpu_evt.halt || cpu_evt.wait_irq)
            cur_level_next = LVL_0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_level_reg    <= LVL_3;
            flags_reg        <= RST_FLAGS;
            jump_if_masked   <= 1'b1;
            jump_if_unmasked <= 1'b0;
        end
        else
        begin
            cur_level_reg    <= cur_level_next;
            jump_if_masked   <= cur_level_next == LVL_3;
            jump_if_unmasked <= cur_level_next != LVL_3;
            if (cpu_evt.irq_return || cpu_evt.pop_cc)
                flags_reg <= {cpu_evt.pop_data[4], cpu_evt.pop_data[2:0]};
        end
    end

    always_comb
    begin
        cond_code_reg = {2'b11, cur_level_reg[1], flags_reg[3], cur_level_reg[0],
                         flags_reg[2:0]};
    end

    // vector being serviced, and the entry address handed to the core
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            active_vec_reg   <= 4'h0;
            active_valid_reg <= 1'b0;
            service_vector   <= VEC_RESET;
        end
        else if (cpu_evt.trap_enter)
        begin
            active_valid_reg <= 1'b0;
            service_vector   <= VEC_TRAP;
        end
        else if (cpu_evt.irq_enter)
        begin
            active_vec_reg   <= cpu_evt.vec_sel;
            active_valid_reg <= cpu_evt.vec_sel < 4'(NUM_VEC);
            service_vector   <= VEC_PAIR0 - {11'h000, cpu_evt.vec_sel, 1'b0};
        end
        else if (cpu_evt.irq_return)
        begin
            // only one level of tracking: a return ends re-entry watching
            active_valid_reg <= 1'b0;
        end
    end

    // a raised priority on the running, still pending vector asks for re-entry;
    // any other change simply waits in the store for the next request
    logic [1:0] new_pair;
    always_comb
    begin
        new_pair    = reg_wdata[2 * active_vec_reg[1:0] +: 2];
        reentry_hit = reg_wr && active_valid_reg &&
                      reg_addr == OFF_SW_PRIO_0 + {6'h00, active_vec_reg[3:2]} &&
                      new_pair != LVL_0 && req[active_vec_reg] &&
                      level_rank(new_pair) > level_rank(prio_reg[active_vec_reg]);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reentry_req <= 1'b0;
            wake_req    <= 1'b0;
            irq_pending <= 14'h0000;
        end
        else
        begin
            reentry_req <= reentry_hit;
            irq_pending <= req;
            if (power.in_active_halt && FLASH_PART)
                wake_req <= req[SRC_TIME_BASE];
            else if (power.in_halt || power.in_active_halt)
                wake_req <= |(req & HALT_WAKE_MASK);
            else
                wake_req <= 1'b0;
        end
    end

    // register reads, data in the following cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                OFF_SW_PRIO_0,
                OFF_SW_PRIO_0 + 8'h01,
                OFF_SW_PRIO_0 + 8'h02:
                    reg_rdata <= {prio_reg[4 * (reg_addr - OFF_SW_PRIO_0) + 3],
                                  prio_reg[4 * (reg_addr - OFF_SW_PRIO_0) + 2],
                                  prio_reg[4 * (reg_addr - OFF_SW_PRIO_0) + 1],
                                  prio_reg[4 * (reg_addr - OFF_SW_PRIO_0)]};
                OFF_SW_PRIO_3:
                    reg_rdata <= {PRIO3_FIXED_HI, prio_reg[13], prio_reg[12]};
                OFF_EXT_SENSE:
                    reg_rdata <= sense_reg;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

    prio_keep_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        reg_wr && reg_addr == OFF_SW_PRIO_0 && reg_wdata[1:0] == LVL_0
        |=> prio_reg[0] == $past(prio_reg[0]))
        else $error("level-0 write changed a priority pair");

    prio3_ones_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        reg_rd && reg_addr == OFF_SW_PRIO_3 |=> reg_rdata[7:4] == 4'hf)
        else $error("fourth priority register upper bits not ones");

    trap_level_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cpu_evt.trap_enter |=> cur_level_reg == LVL_3 && service_vector == VEC_TRAP)
        else $error("trap did not give level 3");

    enable_level_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cpu_evt.enable_irq && !cpu_evt.trap_enter && !cpu_evt.irq_enter &&
        !cpu_evt.irq_return && !cpu_evt.pop_cc && !cpu_evt.disable_irq
        |=> cur_level_reg == LVL_0 ##1 jump_if_unmasked)
        else $error("enable did not load level code 10");

    jump_flags_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        jump_if_masked == (cur_level_reg == LVL_3) && jump_if_unmasked != jump_if_masked)
        else $error("jump flags disagree with current level");

    sense_locked_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        reg_wr && reg_addr == OFF_EXT_SENSE && cur_level_reg != LVL_3 |=> $stable(sense_reg))
        else $error("sense control changed below level 3");

    sense_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        sense_change |=> (ext_pend_reg & ~$past(edge_set)) == 4'h0)
        else $error("sense change left a pending request");

    edge_ack_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cpu_evt.irq_enter && cpu_evt.vec_sel == SRC_EXT0 && !edge_set[0] |=> !ext_pend_reg[0])
        else $error("edge request not cleared on entry");

    level_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        mode[3][1] && !ext_line[3] |=> irq_pending[SRC_EXT0 + 4'h3])
        else $error("low level request not held");

    active_wake_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        power.in_active_halt && FLASH_PART && !req[SRC_TIME_BASE] |=> !wake_req)
        else $error("active halt woken by other source");

    reentry_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        reentry_req |-> $past(active_valid_reg) && $past(req[active_vec_reg]))
        else $error("re-entry without running pending vector");
endmodule

// ==== tb/nic_cpu_model.sv ====
// behavioural cpu core that issues one-cycle event pulses to the block
`timescale 1ns/1ps
module nic_cpu_model (
    // clock
    input  wire logic             core_clk,
    // event pulses toward the block
    output nic_pkg::nic_cpu_evt_t cpu_evt
);
    import nic_pkg::*;

    initial cpu_evt = '0;

    // kind 0..7 picks irq_enter .. wait_irq; one call raises a single flag,
    // so two events never share a cycle and the bus drops to zero between them
    task automatic pulse(input int kind, input logic [3:0] vec, input logic [7:0] data);
        nic_cpu_evt_t ev;
        ev = '0;
        ev[19 - kind] = 1'b1;
        ev.vec_sel = vec;
        ev.pop_data = data;
        @(posedge core_clk);
        cpu_evt <= ev;
        @(posedge core_clk);
        cpu_evt <= '0;
    endtask
endmodule

// ==== tb/tb_nested_irq_priority_and_ext_sense.sv ====
// self-checking bench for the priority store, level tracking and line sensing
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb_nested_irq_priority_and_ext_sense;
    import nic_pkg::*;
    localparam int EV_ENTER = 0;
    localparam int EV_TRAP  = 1;
    localparam int EV_RET   = 2;
    localparam int EV_POP   = 3;
    localparam int EV_EN    = 4;
    localparam int EV_DIS   = 5;
    localparam int EV_HALT  = 6;
    localparam int EV_WAIT  = 7;
    logic         core_clk;
    logic         rst_b;
    logic [7:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [7:0]   reg_rdata;
    nic_cpu_evt_t cpu_evt;
    nic_power_t   power;
    logic [7:0]   cond_code_reg;
    logic         jump_if_masked;
    logic         jump_if_unmasked;
    logic [15:0]  service_vector;
    logic         reentry_req;
    logic         wake_req;
    logic [3:0]   ext_line;
    logic [13:0]  periph_pend;
    logic [13:0]  irq_pending;
    logic [7:0]   prio [4];
    logic [7:0]   d;
    logic [7:0]   pd;
    logic [7:0]   cfg;
    logic [3:0]   st;
    logic [3:0]   inv;
    int           cnt;
    int           err_count;
    int           num_checks;
    int           ev_seq [6] = '{EV_EN, EV_DIS, EV_HALT, EV_TRAP, EV_WAIT, EV_DIS};
    logic [1:0]   lv_seq [6] = '{2'b10, 2'b11, 2'b10, 2'b11, 2'b10, 2'b11};

    nic_cpu_model cpu (.core_clk(core_clk), .cpu_evt(cpu_evt));

    nic_top #(.FLASH_PART(1'b1)) DUT (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_evt(cpu_evt),
        .power(power), .cond_code_reg(cond_code_reg), .jump_if_masked(jump_if_masked),
        .jump_if_unmasked(jump_if_unmasked), .service_vector(service_vector),
        .reentry_req(reentry_req), .wake_req(wake_req), .ext_line(ext_line),
        .periph_pend(periph_pend), .irq_pending(irq_pending));

    always #20 core_clk = ~core_clk;

    function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] nw);
        for (int i = 0; i < 4; i++)
            prio_merge[2*i+:2] = (nw[2*i+:2] == 2'b10) ? old[2*i+:2] : nw[2*i+:2];
    endfunction

    // request seen after the pin moved to level 'to'
    function automatic logic sense_hit(input logic [1:0] c, input logic iv, input logic to);
        return (c == 2'b11) || ((c == 2'b01) ? (to != iv) : (to == iv));
    endfunction

    task automatic reg_write(input logic [7:0] a, input logic [7:0] wd);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= wd;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] rd);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic prio_write(input int i, input logic [7:0] wd);
        reg_write(OFF_SW_PRIO_0 + 8'(i), wd);
        prio[i] = prio_merge(prio[i], wd);
        if (i == 3)
            prio[3][7:4] = 4'hf;
    endtask

    task automatic count_reentry(output int c);
        c = 0;
        repeat (4)
        begin
            #1;
            if (reentry_req === 1'b1)
                c++;
            @(posedge core_clk);
        end
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // a hang anywhere ends the run through the same report
    initial
    begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        power = '0;
        ext_line = 4'hf;
        periph_pend = '0;
        err_count = 0;
        num_checks = 0;
        for (int i = 0; i < 4; i++)
            prio[i] = 8'hff;
        void'($urandom(32'h1d0d));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1 `CHK("reset level", 2'b11, {cond_code_reg[5], cond_code_reg[3]})
        `CHK("masked jump", 2'b10, {jump_if_masked, jump_if_unmasked})
        `CHK("reset vector", 16'hfffe, service_vector)
        for (int i = 0; i < 5; i++)
        begin
            reg_read(OFF_SW_PRIO_0 + 8'(i), d);
            `CHK("reset value", (i == 4) ? 8'h00 : 8'hff, d)
        end
        reg_read(8'h20, d);
        `CHK("unmapped read", 8'h00, d)
        done("reset");
        prio_write(0, 8'hcf);
        prio_write(0, 8'h64);
        reg_read(OFF_SW_PRIO_0, d);
        `CHK("level0 write kept", 8'h44, d)
        for (int k = 0; k < 24; k++)
        begin
            cnt = $urandom_range(3);
            prio_write(cnt, 8'($urandom));
            reg_read(OFF_SW_PRIO_0 + 8'(cnt), d);
            `CHK("prio readback", prio[cnt], d)
        end
        done("priority store");
        for (int k = 0; k < 6; k++)
        begin
            cpu.pulse(ev_seq[k], 4'h0, 8'h00);
            #1 `CHK("instr level", lv_seq[k], {cond_code_reg[5], cond_code_reg[3]})
            `CHK("jump flags", {lv_seq[k] == 2'b11, lv_seq[k] != 2'b11}, {jump_if_masked, jump_if_unmasked})
            if (ev_seq[k] == EV_TRAP)
                `CHK("trap vector", 16'hfffc, service_vector)
        end
        done("instructions");
        for (int n = 0; n < 14; n++)
        begin
            cpu.pulse(EV_ENTER, 4'(n), 8'h00);
            #1 `CHK("entry level", prio[n/4][2*(n%4)+:2], {cond_code_reg[5], cond_code_reg[3]})
            `CHK("entry vector", 16'hfffa - 16'(2*n), service_vector)
            pd = 8'($urandom);
            cpu.pulse((n % 2) ? EV_POP : EV_RET, 4'h0, pd);
            #1 `CHK("restored cc", pd[5:0], cond_code_reg[5:0])
        end
        done("entry and return");
        prio_write(1, 8'h7f);
        @(posedge core_clk);
        periph_pend <= 14'h0080;
        cpu.pulse(EV_ENTER, 4'h7, 8'h00);
        prio_write(1, 8'h3f);
        count_reentry(cnt);
        `CHK("raise reenters", 1, cnt)
        prio_write(1, 8'h7f);
        count_reentry(cnt);
        `CHK("lower no reentry", 0, cnt)
        cpu.pulse(EV_RET, 4'h0, 8'h28);
        done("reentry");
        for (int a = 0; a < 2; a++)
            for (int n = 0; n < 14; n++)
            begin
                if (n >= 2 && n <= 5)
                    continue;
                @(posedge core_clk);
                power <= '{in_halt: 1'b1, in_active_halt: a[0]};
                periph_pend <= 14'(1 << n);
                repeat (3) @(posedge core_clk);
                #1 `CHK("source pending", 1'b1, irq_pending[n])
                `CHK("halt wake", a ? n == 1 : (n == 1 || n == 7), wake_req)
            end
        @(posedge core_clk);
        power <= '0;
        periph_pend <= '0;
        done("halt wake");
        cpu.pulse(EV_EN, 4'h0, 8'h00);
        reg_write(OFF_EXT_SENSE, 8'hfc);
        reg_read(OFF_EXT_SENSE, d);
        `CHK("sense locked", 8'h00, d)
        cpu.pulse(EV_DIS, 4'h0, 8'h00);
        reg_write(OFF_EXT_SENSE, 8'hfc);
        reg_read(OFF_EXT_SENSE, d);
        `CHK("sense written", 8'hfc, d)
        done("sense access");
        // level-qualified codes start from the idle level only
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < 2; p++)
                for (int s = 0; s < 2; s++)
                begin
                    if (c == 0 && s == 0)
                        continue;
                    cfg = {c[1:0], p[0], c[1:0], p[0], 2'b00};
                    inv = {1'b0, p[0], 1'b0, p[0]};
                    st = {4{s[0]}} ^ inv;
                    cpu.pulse(EV_DIS, 4'h0, 8'h00);
                    @(posedge core_clk);
                    ext_line <= st;
                    repeat (3) @(posedge core_clk);
                    reg_write(OFF_EXT_SENSE, cfg ^ 8'h04);
                    reg_write(OFF_EXT_SENSE, cfg);
                    repeat (2) @(posedge core_clk);
                    #1 `CHK("sense change clears", 4'h0, irq_pending[5:2])
                    @(posedge core_clk);
                    ext_line <= ~st;
                    repeat (3) @(posedge core_clk);
                    #1;
                    for (int l = 0; l < 4; l++)
                        `CHK("line trigger", sense_hit(c[1:0], inv[l], ~st[l]), irq_pending[l+2])
                    for (int l = 0; l < 4; l++)
                    begin
                        cpu.pulse(EV_ENTER, 4'(l + 2), 8'h00);
                        repeat (2) @(posedge core_clk);
                        #1 `CHK("after entry", c == 0 && ~st[l] == inv[l], irq_pending[l+2])
                    end
                end
        done("line sensing");
        give_verdict();
    end
endmodule
